// [common/fsrc_map.svh]
// Purpose : offsets, field positions, encodings, command codes and counts for the
//           flash security and reset-sequence block
// Assumes : included by bare name; definitions only
// Notes   : register offsets are word indices on the plain register port
`ifndef FSRC_MAP_SVH
`define FSRC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FSRC_OFS_CMD      4'h0
`define FSRC_OFS_STAT     4'h1
`define FSRC_OFS_SEC      4'h2
`define FSRC_OFS_PROT     4'h3
`define FSRC_OFS_OPT      4'h4
`define FSRC_OFS_KEY_LO   4'h5
`define FSRC_OFS_KEY_HI   4'h6
`define FSRC_OFS_MODE     4'h7

// ----------------------------------------------------------------------
// security register field positions
// ----------------------------------------------------------------------
`define FSRC_SEC_STATE_LSB  0
`define FSRC_SEC_FACT_LSB   2
`define FSRC_SEC_MASS_LSB   4
`define FSRC_SEC_BACKDOOR_KEY_ENABLE_LSB  6

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define FSRC_SEC_UNSECURE   2'h2
`define FSRC_BACKDOOR_KEY_ENABLE_ENABLED  2'h2

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define FSRC_CMD_ERASE_ALL  8'h44
`define FSRC_CMD_VERIFY_KEY 8'h45
`define FSRC_CMD_READ_ONES  8'h40

// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define FSRC_STAT_DONE_BIT  7
`define FSRC_STAT_ACC_BIT   5
`define FSRC_STAT_HOLD_BIT  0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSRC_CMD_CYCLES     8'h10
`define FSRC_LOAD_CYCLES    4'h4

`endif

// [common/fsrc_pkg.sv]
// Purpose : types shared by the flash security and reset-sequence block
// Assumes : nothing beyond the map header
// Notes   : the security register is one byte of four 2-bit fields
package fsrc_pkg;

  typedef struct packed {
    logic [1:0] backdoor_key_enable;
    logic [1:0] mass_erase_enable;
    logic [1:0] factory_access_level;
    logic [1:0] sec_state;
  } fsrc_sec_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fsrc_bus_s;

  typedef enum logic [2:0] {
    FSRC_RST_LOAD = 3'b000,
    FSRC_IDLE     = 3'b001,
    FSRC_EXEC     = 3'b010,
    FSRC_DONE     = 3'b011
  } fsrc_state_e;

endpackage

// [rtl/fsrc_key_check.sv]
// Purpose : combinational backdoor-key comparison
// Assumes : both keys are stable while the check is read
// Notes   : all-zero and all-one keys always fail
module fsrc_key_check
  import fsrc_pkg::*;
(
  // keys
  input  wire logic [63:0] key_in,
  input  wire logic [63:0] key_stored,
  // result
  output logic             key_match,
  output logic             key_illegal
);

  // ----------------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------------
  // illegal patterns checked before any match is honoured
  assign key_illegal = (key_in == 64'h0000000000000000) ||
                       (key_in == 64'hFFFFFFFFFFFFFFFF);
  assign key_match   = !key_illegal && (key_in == key_stored);

endmodule

// [rtl/fsrc_sync.sv]
// Purpose : two-flop synchroniser for a bundle of pin levels
// Assumes : inputs are levels, not pulses
// Notes   : the first stage is read only by the second
module fsrc_sync
  import fsrc_pkg::*;
#(
  parameter int W = 2
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  // ----------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // two registers before anyone looks at the level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end

  assign d_out = s2_q;

endmodule

// [rtl/fsrc_core.sv]
// Purpose : security register, command gating, backdoor unlock and
//           reset sequence of the flash controller
// Assumes : one clock; flash array answers stored bytes combinationally
// Notes   : the array itself and program/erase timing are outside
//
// What this block does
// - reset loads security register from stored byte
// - security register has four fields
// - secured special mode allows erase-all, read-ones only
// - reprogrammed security byte applies after next reset
// - backdoor unlock only when key enable set
// - key match forces unsecure state
// - wrong legal key blocks further verify until reset; all-zero or all-one key does not
// - key match changes live register only
// - next reset restores stored security state
// - key verify leaves protection registers alone
// - reset sequence loads config, protection, option, security
// - complete flag clear in sequence, set after
// - stall processor flash access during sequence
// - reset aborts command in flight at once
// - interrupted commands never resume after reset
// - unlocked chip may erase and reprogram config
// - all-zero or all-one key fails
// - verify with key disabled sets access error
// - verified erase-all writes unsecure state
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "fsrc_map.svh"
module fsrc_core
  import fsrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // flash configuration field, read from the array
  input  wire logic [7:0]  cfg_sec_byte,
  input  wire logic [7:0]  cfg_prot_byte,
  input  wire logic [7:0]  cfg_opt_byte,
  input  wire logic [63:0] cfg_backdoor_key,
  input  wire logic        erase_verify_ok,
  // operating mode pin
  input  wire logic        special_mode,
  // to processor and access control
  output logic             cpu_hold,
  output logic      [7:0]  security_register,
  output logic             chip_secure,
  output logic             command_complete_flag,
  output logic             access_error_flag,
  output logic             cmd_active,
  output logic      [7:0]  cmd_code
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  fsrc_state_e st_q, st_d;
  fsrc_sec_s   sec_q, sec_d;
  logic [7:0]  prot_q, prot_d;
  logic [7:0]  opt_q, opt_d;
  logic [63:0] key_q, key_d;
  logic [7:0]  cmd_q, cmd_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        acc_q, acc_d;
  logic        lock_q, lock_d;
  logic        mode_q, mode_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        mode_sync;
  logic        key_match;
  logic        key_illegal;
  logic        secure;
  logic        cmd_ok;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // command allowed by mode and security state
  function automatic logic cmd_allowed(input logic [7:0] c,
                                       input logic sec,
                                       input logic spec);
    if (!sec)
      cmd_allowed = 1'b1;
    else if (spec)
      cmd_allowed = (c == `FSRC_CMD_ERASE_ALL) ||
                    (c == `FSRC_CMD_READ_ONES);
    else
      cmd_allowed = 1'b1;
  endfunction

  // mode pin comes from outside the clock domain
  fsrc_sync #(.W(1)) u_sync
  (
    .clk    (clk),
    .arst_n (arst_n),
    .d_in   (special_mode),
    .d_out  (mode_sync)
  );

  fsrc_key_check u_key
  (
    .key_in      (key_q),
    .key_stored  (cfg_backdoor_key),
    .key_match   (key_match),
    .key_illegal (key_illegal)
  );

  assign secure = (sec_q.sec_state != `FSRC_SEC_UNSECURE);
  assign cmd_ok = cmd_allowed(reg_wdata, secure, mode_q);

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  // sequence and command engine; reset drops st_q to load, which is
  // both the abort of a running command and the refusal to resume it
  always_comb
  begin
    st_d    = st_q;
    sec_d   = sec_q;
    prot_d  = prot_q;
    opt_d   = opt_q;
    key_d   = key_q;
    cmd_d   = cmd_q;
    cnt_d   = cnt_q;
    acc_d   = acc_q;
    lock_d  = lock_q;
    mode_d  = mode_q;
    rdata_d = 8'h00;
    unique case (st_q)
      FSRC_RST_LOAD:
      begin
        // loads repeat every cycle so the last read wins
        sec_d  = fsrc_sec_s'(cfg_sec_byte);
        prot_d = cfg_prot_byte;
        opt_d  = cfg_opt_byte;
        mode_d = mode_sync;
        cnt_d  = cnt_q + 8'h01;
        if (cnt_q == {4'h0, `FSRC_LOAD_CYCLES})
        begin
          st_d  = FSRC_IDLE;
          cnt_d = 8'h00;
        end
      end
      FSRC_IDLE:
      begin
        if (reg_wr && reg_addr == `FSRC_OFS_CMD)
        begin
          cmd_d = reg_wdata;
          cnt_d = 8'h00;
          if (!cmd_ok)
            acc_d = 1'b1;
          else
            st_d = FSRC_EXEC;
        end
      end
      FSRC_EXEC:
      begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == `FSRC_CMD_CYCLES)
          st_d = FSRC_DONE;
      end
      FSRC_DONE:
      begin
        st_d = FSRC_IDLE;
        if (cmd_q == `FSRC_CMD_VERIFY_KEY)
        begin
          // only the live register moves; stored bytes and
          // protection stay as they are
          if (sec_q.backdoor_key_enable != `FSRC_BACKDOOR_KEY_ENABLE_ENABLED)
            acc_d = 1'b1;
          else if (lock_q || key_illegal)
            acc_d = 1'b1;
          else if (key_match)
            sec_d.sec_state = `FSRC_SEC_UNSECURE;
          else
          begin
            acc_d  = 1'b1;
            lock_d = 1'b1;
          end
        end
        else if (cmd_q == `FSRC_CMD_ERASE_ALL && erase_verify_ok)
          sec_d.sec_state = `FSRC_SEC_UNSECURE;
      end
      default:
        st_d = FSRC_RST_LOAD;
    endcase
    // register writes; the key may be loaded at any time
    if (reg_wr && reg_addr == `FSRC_OFS_KEY_LO)
      key_d = {key_q[63:8], reg_wdata};
    if (reg_wr && reg_addr == `FSRC_OFS_KEY_HI)
      key_d = {key_q[55:0], reg_wdata};
    // a write of one to the error bit clears it, unless the bit is being set from clear in the same cycle
    if (reg_wr && reg_addr == `FSRC_OFS_STAT &&
        reg_wdata[`FSRC_STAT_ACC_BIT] && !(acc_d && !acc_q))
      acc_d = 1'b0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `FSRC_OFS_CMD:    rdata_d = cmd_q;
        `FSRC_OFS_STAT:   rdata_d = {command_complete_flag, 1'b0, acc_q,
                                     4'h0, cpu_hold};
        `FSRC_OFS_SEC:    rdata_d = sec_q;
        `FSRC_OFS_PROT:   rdata_d = prot_q;
        `FSRC_OFS_OPT:    rdata_d = opt_q;
        `FSRC_OFS_KEY_LO: rdata_d = key_q[7:0];
        `FSRC_OFS_KEY_HI: rdata_d = key_q[63:56];
        `FSRC_OFS_MODE:   rdata_d = {7'h00, mode_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // asynchronous reset kills any command at once and restarts loading
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q    <= FSRC_RST_LOAD;
      sec_q   <= '0;
      prot_q  <= 8'h00;
      opt_q   <= 8'h00;
      key_q   <= 64'h0000000000000000;
      cmd_q   <= 8'h00;
      cnt_q   <= 8'h00;
      acc_q   <= 1'b0;
      lock_q  <= 1'b0;
      mode_q  <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      st_q    <= st_d;
      sec_q   <= sec_d;
      prot_q  <= prot_d;
      opt_q   <= opt_d;
      key_q   <= key_d;
      cmd_q   <= cmd_d;
      cnt_q   <= cnt_d;
      acc_q   <= acc_d;
      lock_q  <= lock_d;
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // live security straight from the register, no delay
  assign security_register     = sec_q;
  assign chip_secure           = secure;
  assign cpu_hold              = (st_q == FSRC_RST_LOAD);
  assign command_complete_flag = (st_q == FSRC_IDLE);
  assign access_error_flag     = acc_q;
  assign cmd_active            = (st_q == FSRC_EXEC) ||
                                 (st_q == FSRC_DONE);
  assign cmd_code              = cmd_q;
  assign reg_rdata             = rdata_q;

endmodule

// [tb/fsrc_core_assertions.sv]
// Purpose : port checker for the flash security and reset-sequence core
// Assumes : one clock, asynchronous active-low reset
// Notes   : bound to every instance of the core
`include "fsrc_map.svh"
module fsrc_core_chk
  import fsrc_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // register port
  input wire logic       reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // array and status
  input wire logic [7:0] cfg_sec_byte,
  input wire logic       cpu_hold,
  input wire logic [7:0] security_register,
  input wire logic       chip_secure,
  input wire logic       command_complete_flag,
  input wire logic       access_error_flag,
  input wire logic       cmd_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------------
  // reset sequence
  // ------------------------------------------------------------------
  AST_HOLD_FLAG: assert property (cpu_hold |-> !command_complete_flag)
    else $error("flag set while processor held");
  AST_RST_HOLD: assert property ($rose(arst_n) |-> cpu_hold)
    else $error("no hold right after reset");
  AST_SEQ_END: assert property ($rose(arst_n) |-> ##[3:8] command_complete_flag)
    else $error("reset sequence too long");
  // cfg is held still by the bench while the sequence runs
  AST_LOAD: assert property ($fell(cpu_hold) |-> security_register == cfg_sec_byte)
    else $error("security not loaded from stored byte");
  // ------------------------------------------------------------------
  // security and commands
  // ------------------------------------------------------------------
  AST_SECURE_OUT: assert property (chip_secure == (security_register[1:0] != `FSRC_SEC_UNSECURE))
    else $error("secure output disagrees with register");
  AST_CMD_FLAG: assert property (cmd_active |-> !command_complete_flag)
    else $error("flag set during command");
  AST_CMD_LEN: assert property ($rose(cmd_active) |-> ##[1:20] command_complete_flag)
    else $error("command never completes");
  // only command ends and resets may move the live register
  AST_SEC_IDLE: assert property (command_complete_flag && $past(command_complete_flag) |-> $stable(security_register))
    else $error("security changed while idle");
  AST_ERR_HOLD: assert property (access_error_flag && !(reg_wr && reg_addr == `FSRC_OFS_STAT && reg_wdata[`FSRC_STAT_ACC_BIT]) |=> access_error_flag)
    else $error("access error lost without clear");

  CV_UNLOCK: cover property ($fell(chip_secure));
  CV_ERR: cover property ($rose(access_error_flag));
  CV_CMD: cover property ($rose(cmd_active));
endmodule

bind fsrc_core fsrc_core_chk i_chk (.clk, .arst_n, .reg_wr, .reg_addr,
  .reg_wdata, .cfg_sec_byte, .cpu_hold, .security_register, .chip_secure,
  .command_complete_flag, .access_error_flag, .cmd_active);

// [tb/fsrc_flash_model.sv]
// Purpose : flash configuration field seen from the core
// Assumes : bench programs the security byte before reset release
// Notes   : bytes are levels; no array timing is modelled
module fsrc_flash_model
  import fsrc_pkg::*;
#(
  parameter logic [63:0] KEY  = 64'h0123_4567_89AB_CDEF,
  parameter logic [7:0]  PROT = 8'h5A,
  parameter logic [7:0]  OPT  = 8'h3C
)
(
  // clock
  input  wire logic        clk,
  // programming of the stored security byte
  input  wire logic        pgm_en,
  input  wire logic [7:0]  pgm_sec,
  input  wire logic        erase_ok,
  // configuration field toward the core
  output logic      [7:0]  cfg_sec_byte,
  output logic      [7:0]  cfg_prot_byte,
  output logic      [7:0]  cfg_opt_byte,
  output logic      [63:0] cfg_backdoor_key,
  output logic             erase_verify_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // only a program step moves the stored byte, never a key match
  always_ff @(posedge clk)
    if (pgm_en)
      cfg_sec_byte <= pgm_sec;
  assign cfg_prot_byte    = PROT;
  assign cfg_opt_byte     = OPT;
  assign cfg_backdoor_key = KEY;
  assign erase_verify_ok  = erase_ok;
endmodule

// [tb/tb_flash_security_reset_control.sv]
// Purpose : self-checking bench for the flash security core
// Assumes : 50 MHz clock, bench drives on rising edges
// Notes   : each scenario starts from a fresh reset where it matters
`include "fsrc_map.svh"
module tb_flash_security_reset_control;
  timeunit 1ns;
  timeprecision 1ns;
  import fsrc_pkg::*;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  localparam logic [7:0]  PROT = 8'h5A;
  localparam logic [7:0]  OPT  = 8'h3C;
  localparam logic [7:0]  SEC0 = 8'h80;
  localparam logic [7:0]  VK = `FSRC_CMD_VERIFY_KEY;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        spec = 1'b0;
  logic [7:0]  pgm_sec = SEC0;
  fsrc_bus_s   bus = '0;
  logic [7:0]  rdata, sreg, got, code, cs, cp, co;
  logic [63:0] ck;
  logic        ev, hold, sec, done, aerr, act;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #10 clk = ~clk;

  fsrc_flash_model #(.KEY(KEY), .PROT(PROT), .OPT(OPT)) i_flash (.clk(clk),
    .pgm_en(1'b1), .pgm_sec(pgm_sec), .erase_ok(1'b1), .cfg_sec_byte(cs),
    .cfg_prot_byte(cp), .cfg_opt_byte(co), .cfg_backdoor_key(ck),
    .erase_verify_ok(ev));
  fsrc_core i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(bus.addr),
    .reg_wdata(bus.wdata), .reg_wr(bus.wr), .reg_rd(bus.rd),
    .reg_rdata(rdata), .cfg_sec_byte(cs), .cfg_prot_byte(cp),
    .cfg_opt_byte(co), .cfg_backdoor_key(ck), .erase_verify_ok(ev),
    .special_mode(spec), .cpu_hold(hold), .security_register(sreg),
    .chip_secure(sec), .command_complete_flag(done),
    .access_error_flag(aerr), .cmd_active(act), .cmd_code(code));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) bus <= '0;
    #1 got = rdata;
  endtask

  // bounded wait so a stuck flag ends as a mismatch, not a hang
  task automatic wait_done;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (done === 1'b1)
        return;
    end
    chk(8'(done), 8'h01, "no completion");
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(`FSRC_OFS_CMD, c);
    wait_done();
  endtask

  task automatic rst;
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wait_done();
  endtask

  task automatic load_key(input logic [63:0] k);
    for (int i = 7; i >= 0; i--)
      wr(`FSRC_OFS_KEY_HI, k[i*8+:8]);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_load;
    chk(sreg, SEC0, "live security after reset");
    chk(8'(hold), 8'h00, "hold not released");
    rd(`FSRC_OFS_PROT);
    chk(got, PROT, "protection not loaded");
    rd(`FSRC_OFS_OPT);
    chk(got, OPT, "option not loaded");
    rd(`FSRC_OFS_SEC);
    chk(got, SEC0, "security fields read back");
    $display("test load finished");
  endtask

  // a wrong key locks out even the right key until reset
  task automatic t_bad_key;
    load_key(KEY ^ 64'h1);
    cmd(VK);
    chk(8'(aerr), 8'h01, "wrong key accepted");
    load_key(KEY);
    cmd(VK);
    chk(sreg, SEC0, "unlock after failed key");
    $display("test bad key finished");
  endtask

  task automatic t_unlock;
    rst();
    load_key(KEY);
    cmd(VK);
    chk(sreg, 8'h82, "key match did not unsecure");
    chk(8'(sec), 8'h00, "secure output stale");
    rd(`FSRC_OFS_PROT);
    chk(got, PROT, "protection moved by key");
    @(posedge clk) pgm_sec <= 8'hC0;
    repeat (2) @(posedge clk);
    #1 chk(sreg, 8'h82, "new byte applied early");
    rst();
    chk(sreg, 8'hC0, "reset did not restore");
    load_key(KEY);
    cmd(VK);
    chk(8'(aerr), 8'h01, "disabled key not refused");
    chk(sreg, 8'hC0, "unlock with key disabled");
    $display("test unlock finished");
  endtask

  task automatic t_zero_key;
    @(posedge clk) pgm_sec <= SEC0;
    rst();
    load_key(64'h0);
    cmd(VK);
    chk(8'(aerr), 8'h01, "zero key accepted");
    $display("test zero key finished");
  endtask

  task automatic t_special;
    @(posedge clk) spec <= 1'b1;
    rst();
    cmd(VK);
    chk(8'(aerr), 8'h01, "command allowed while secured");
    wr(`FSRC_OFS_STAT, 8'h20);
    cmd(`FSRC_CMD_READ_ONES);
    chk(8'(aerr), 8'h00, "read-ones refused");
    cmd(`FSRC_CMD_ERASE_ALL);
    chk({6'h00, sreg[1:0]}, 8'h02, "erase-all kept security");
    chk(code, `FSRC_CMD_ERASE_ALL, "last command code wrong");
    @(posedge clk) spec <= 1'b0;
    $display("test special finished");
  endtask

  // reset lands in mid-command; nothing may resume afterwards
  task automatic t_abort;
    rst();
    wr(`FSRC_OFS_CMD, `FSRC_CMD_ERASE_ALL);
    repeat (3) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1 chk(8'(act), 8'h00, "command survived reset");
    @(posedge clk) arst_n <= 1'b1;
    wait_done();
    repeat (25) @(posedge clk);
    #1 chk(8'(act), 8'h00, "command resumed");
    chk(8'(done), 8'h01, "flag dropped after reset");
    $display("test abort finished");
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wait_done();
    t_load();
    t_bad_key();
    t_unlock();
    t_zero_key();
    t_special();
    t_abort();
    report_and_stop();
  end
endmodule
